// [src/guc_counter.sv]
/*
  gated 32-bit signed up/down event counter with continuous, once and
  periodic modes, main direction, hardware/software gate, latch, flags.
  assumes count pulses, hardware gate and latch come from field pins
  (asynchronous) and registers sit behind an ahb-lite slave on mclk.
*/
// Operation
// - no main direction: full signed range
// - forward: load to end-1, then load
// - backward: load to end+1, then load
// - hw gate enabled: software_gate_bit only pauses
// - cancel: reopen reloads the load value
// - stop: reopen resumes last value
// - continuous: upper limit up wraps to lower
// - continuous: lower limit down wraps to upper
// - sticky overflow/underflow until status clear
// - process interrupt on overflow/underflow when enabled
// - once, no direction: wrap, close gate, flag
// - once forward: after end-1, reload and close
// - once backward: after end+1, reload and close
// - once with direction: gate rise restarts
// - periodic no direction: wrap, gate stays open
// - periodic forward: after end-1 reload, continue
// - periodic backward: reload after end+1
// - internal gate combines hw and sw gates
// - hw gate opens on rise, closes on fall
// - latch rise copies count to latch register
// - latch value kept across stop to run
module guc_counter (
  input wire logic mclk,
  input wire logic reset,
  input wire logic countPulse,
  input wire logic countDown,
  input wire logic hwGateIn,
  input wire logic latchIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic processIrq
);
  import guc_pkg::*;

  // ==========================================
  // register map
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_LOAD = 8'h0c;
  localparam logic [7:0] OFS_END = 8'h10;
  localparam logic [7:0] OFS_LATCH = 8'h14;

  // ==========================================
  // pin inputs
  logic pulseRise, dirLvl, hwLvl, hwRise, hwFall, latchRise;

  guc_input_sync uPulse (.mclk(mclk), .reset(reset), .asyncIn(countPulse),
    .level(), .rise(pulseRise), .fall());
  guc_input_sync uDir (.mclk(mclk), .reset(reset), .asyncIn(countDown),
    .level(dirLvl), .rise(), .fall());
  guc_input_sync uHw (.mclk(mclk), .reset(reset), .asyncIn(hwGateIn),
    .level(hwLvl), .rise(hwRise), .fall(hwFall));
  guc_input_sync uLatch (.mclk(mclk), .reset(reset), .asyncIn(latchIn),
    .level(), .rise(latchRise), .fall());

  // ==========================================
  // state
  logic swGate_q, swGate_d;
  logic hwGateEn_q, hwGateEn_d;
  logic gateFunc_q, gateFunc_d;
  logic irqEn_q, irqEn_d;
  logic [1:0] mode_q, mode_d;
  logic [1:0] dir_q, dir_d;
  logic hwGate_q, hwGate_d;
  logic autoClosed_q, autoClosed_d;
  logic readyOut_q, readyOut_d;
  logic respOut_q, respOut_d;
  logic ovf_q, ovf_d;
  logic unf_q, unf_d;
  logic irq_q, irq_d;
  logic [31:0] count_q, count_d;
  logic [31:0] load_q, load_d;
  logic [31:0] end_q, end_d;
  logic [31:0] latch_q, latch_d;
  logic [31:0] rdata_q, rdata_d;
  logic aphWr_q, aphWr_d;
  logic [7:0] aphAddr_q, aphAddr_d;

  // ==========================================
  // bus decode
  logic aphValid, wrCtrl, wrStatus, wrCount, wrLoad, wrEnd, rdTake;
  logic [31:0] endM1, endP1, countInc, countDec;
  logic hwPart, iGate, swRise, hwRestartEdge;

  assign aphValid = hsel & htrans[1] & hready;
  assign wrCtrl = aphWr_q & (aphAddr_q == OFS_CTRL);
  assign wrStatus = aphWr_q & (aphAddr_q == OFS_STATUS);
  assign wrCount = aphWr_q & (aphAddr_q == OFS_COUNT);
  assign wrLoad = aphWr_q & (aphAddr_q == OFS_LOAD);
  assign wrEnd = aphWr_q & (aphAddr_q == OFS_END);
  assign rdTake = aphValid & ~hwrite;

  assign countInc = count_q + 32'h00000001;
  assign countDec = count_q - 32'h00000001;
  assign endM1 = end_q - 32'h00000001;
  assign endP1 = end_q + 32'h00000001;

  // internal gate: hw part forced open when disabled
  assign hwPart = hwGateEn_q ? hwGate_q : 1'b1;
  assign iGate = swGate_q & hwPart & ~autoClosed_q;
  assign swRise = wrCtrl & hwdata[0] & ~swGate_q;
  // gate transition that carries cancel semantics
  assign hwRestartEdge = hwGateEn_q ? (hwRise & swGate_q) : swRise;

  // ==========================================
  // next state
  always_comb begin
    swGate_d = swGate_q;
    hwGateEn_d = hwGateEn_q;
    gateFunc_d = gateFunc_q;
    irqEn_d = irqEn_q;
    mode_d = mode_q;
    dir_d = dir_q;
    hwGate_d = hwGate_q;
    autoClosed_d = autoClosed_q;
    readyOut_d = 1'b1;
    respOut_d = 1'b0;
    ovf_d = ovf_q;
    unf_d = unf_q;
    irq_d = 1'b0;
    count_d = count_q;
    load_d = load_q;
    end_d = end_q;
    latch_d = latch_q;
    rdata_d = rdata_q;
    aphWr_d = aphValid & hwrite;
    aphAddr_d = aphValid ? haddr[7:0] : aphAddr_q;

    // hw gate edge tracking
    if (hwRise) begin
      hwGate_d = 1'b1;
    end else if (hwFall) begin
      hwGate_d = 1'b0;
    end

    // software registers
    if (wrCtrl) begin
      swGate_d = hwdata[0];
      hwGateEn_d = hwdata[1];
      gateFunc_d = hwdata[2];
      irqEn_d = hwdata[3];
      mode_d = hwdata[5:4];
      dir_d = hwdata[7:6];
    end
    if (wrStatus && hwdata[0]) begin
      ovf_d = 1'b0;
      unf_d = 1'b0;
    end
    if (wrLoad) begin
      load_d = hwdata;
    end
    if (wrEnd) begin
      end_d = hwdata;
    end
    if (wrCount) begin
      count_d = hwdata;
    end

    // restart after a gate reopening
    if (autoClosed_q) begin
      if (hwRise || (!hwGateEn_q && swRise)) begin
        autoClosed_d = 1'b0;
        if (dir_q != GUC_DIR_NONE || gateFunc_q == GUC_GATE_CANCEL) begin
          count_d = load_q;
        end
      end
    end else if (hwRestartEdge && gateFunc_q == GUC_GATE_CANCEL) begin
      count_d = load_q;
    end
    // stop function keeps count_q on reopen

    // counting
    if (iGate && pulseRise && !wrCount) begin
      if (!dirLvl) begin
        if (dir_q == GUC_DIR_FWD) begin
          if (count_q == endM1) begin
            count_d = load_q;
            if (mode_q == GUC_MODE_ONCE) begin
              autoClosed_d = 1'b1;
            end
            // periodic keeps gate open
          end else begin
            count_d = countInc;
          end
        end else if (count_q == GUC_UPPER_LIMIT && dir_q == GUC_DIR_NONE) begin
          count_d = GUC_LOWER_LIMIT;
          ovf_d = 1'b1;
          irq_d = irqEn_q;
          if (mode_q == GUC_MODE_ONCE) begin
            autoClosed_d = 1'b1;
          end
          // periodic wraps with gate open
        end else begin
          count_d = countInc;
        end
      end else begin
        if (dir_q == GUC_DIR_BWD) begin
          if (count_q == endP1) begin
            count_d = load_q;
            if (mode_q == GUC_MODE_ONCE) begin
              autoClosed_d = 1'b1;
            end
            // periodic backward reload
          end else begin
            count_d = countDec;
          end
        end else if (count_q == GUC_LOWER_LIMIT && dir_q == GUC_DIR_NONE) begin
          count_d = GUC_UPPER_LIMIT;
          unf_d = 1'b1;
          irq_d = irqEn_q;
          if (mode_q == GUC_MODE_ONCE) begin
            autoClosed_d = 1'b1;
          end
        end else begin
          count_d = countDec;
        end
      end
    end

    if (latchRise) begin
      latch_d = count_q;
    end

    if (rdTake) begin
      case (haddr[7:0])
        OFS_CTRL: rdata_d = {24'h000000, dir_q, mode_q, irqEn_q, gateFunc_q, hwGateEn_q, swGate_q};
        OFS_STATUS: rdata_d = {26'h0000000, dirLvl, hwLvl, iGate, autoClosed_q, unf_q, ovf_q};
        OFS_COUNT: rdata_d = count_q;
        OFS_LOAD: rdata_d = load_q;
        OFS_END: rdata_d = end_q;
        OFS_LATCH: rdata_d = latch_q;
        default: rdata_d = 32'h00000000;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge mclk) begin
    if (reset) begin
      swGate_q <= 1'b0;
      hwGateEn_q <= 1'b0;
      gateFunc_q <= GUC_GATE_CANCEL;
      irqEn_q <= 1'b0;
      mode_q <= GUC_MODE_CONT;
      dir_q <= GUC_DIR_NONE;
      hwGate_q <= 1'b0;
      autoClosed_q <= 1'b0;
      readyOut_q <= 1'b1;
      respOut_q <= 1'b0;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      irq_q <= 1'b0;
      count_q <= GUC_COUNT_RESET;
      load_q <= GUC_LOAD_RESET;
      end_q <= GUC_END_RESET;
      latch_q <= GUC_LATCH_RESET;
      rdata_q <= 32'h00000000;
      aphWr_q <= 1'b0;
      aphAddr_q <= 8'h00;
    end else begin
      swGate_q <= swGate_d;
      hwGateEn_q <= hwGateEn_d;
      gateFunc_q <= gateFunc_d;
      irqEn_q <= irqEn_d;
      mode_q <= mode_d;
      dir_q <= dir_d;
      hwGate_q <= hwGate_d;
      autoClosed_q <= autoClosed_d;
      readyOut_q <= readyOut_d;
      respOut_q <= respOut_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      irq_q <= irq_d;
      count_q <= count_d;
      load_q <= load_d;
      end_q <= end_d;
      latch_q <= latch_d;
      rdata_q <= rdata_d;
      aphWr_q <= aphWr_d;
      aphAddr_q <= aphAddr_d;
    end
  end

  // ==========================================
  // outputs
  assign hrdata = rdata_q;
  assign hreadyout = readyOut_q;
  assign hresp = respOut_q;
  assign processIrq = irq_q;

endmodule : guc_counter

// [src/guc_pkg.sv]
/*
  package of the gated up/down counter: modes, directions, reset values.
  assumes one clock domain at 40 mhz, synchronous active-high reset.
*/
package guc_pkg;

  // ==========================================
  // widths and limits
  localparam int GUC_WIDTH = 32;
  localparam logic [31:0] GUC_LOWER_LIMIT = 32'h80000000;
  localparam logic [31:0] GUC_UPPER_LIMIT = 32'h7fffffff;
  localparam logic [31:0] GUC_COUNT_RESET = 32'h00000000;
  localparam logic [31:0] GUC_LOAD_RESET = 32'h00000000;
  localparam logic [31:0] GUC_END_RESET = 32'h00000064;
  localparam logic [31:0] GUC_LATCH_RESET = 32'h00000000;

  // ==========================================
  // clock
  localparam int GUC_CLOCK_HZ = 40000000;
  localparam int GUC_SYNC_STAGES = 3;

  // ==========================================
  // modes and directions
  typedef enum logic [1:0] {
    GUC_MODE_CONT = 2'h0,
    GUC_MODE_ONCE = 2'h1,
    GUC_MODE_PERIODIC = 2'h2
  } guc_mode_e;

  typedef enum logic [1:0] {
    GUC_DIR_NONE = 2'h0,
    GUC_DIR_FWD = 2'h1,
    GUC_DIR_BWD = 2'h2
  } guc_dir_e;

  // gate function
  localparam logic GUC_GATE_CANCEL = 1'b0;
  localparam logic GUC_GATE_STOP = 1'b1;

endpackage : guc_pkg

// [src/guc_input_sync.sv]
/*
  three-flop synchroniser with a two-stage agreement filter and edge pulses.
  assumes the input is asynchronous to mclk.
*/
module guc_input_sync (
  input wire logic mclk,
  input wire logic reset,
  input wire logic asyncIn,
  output logic level,
  output logic rise,
  output logic fall
);
  import guc_pkg::*;

  // ==========================================
  // sync chain
  logic [2:0] chain_q;
  logic [2:0] chain_d;
  logic level_q;
  logic level_d;
  logic rise_q;
  logic rise_d;
  logic fall_q;
  logic fall_d;

  always_comb begin
    chain_d = {chain_q[1:0], asyncIn};
    level_d = level_q;
    if (chain_q[2] == chain_q[1]) begin
      level_d = chain_q[1];
    end
    rise_d = level_d & ~level_q;
    fall_d = ~level_d & level_q;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      chain_q <= 3'h0;
      level_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      chain_q <= chain_d;
      level_q <= level_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
    end
  end

  assign level = level_q;
  assign rise = rise_q;
  assign fall = fall_q;

endmodule : guc_input_sync

// [tb/guc_counter_asserts.sv]
/* port checker of guc_counter.
   bound to every guc_counter instance, one clock domain. */
module guc_counter_asserts (
  input wire logic mclk,
  input wire logic reset,
  input wire logic countPulse,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic processIrq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ========
  // helpers
  logic rdTake;
  logic [3:0] age_q;
  logic [3:0] age_d;
  assign rdTake = hsel && htrans[1] && hready && !hwrite;
  always_comb begin
    age_d = countPulse ? 4'h0 : (age_q == 4'hf ? age_q : age_q + 4'h1);
  end
  always_ff @(posedge mclk) begin
    age_q <= reset ? 4'hf : age_d;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // ========
  // checks
  a_ready_high: assert property (hreadyout) else $error("hreadyout low");
  a_resp_okay: assert property (!hresp) else $error("hresp not okay");
  a_irq_pulse: assert property (processIrq |=> !processIrq) else $error("irq too long");
  a_irq_cause: assert property (processIrq |-> age_q < 4'hc) else $error("irq without pulse");
  a_irq_reset: assert property ($past(reset) |-> !processIrq) else $error("irq after reset");
  a_rdata_reset: assert property ($past(reset) |-> hrdata == 32'h0) else $error("hrdata after reset");
  a_rdata_hold: assert property (!$past(rdTake) && !$past(reset) |-> $stable(hrdata))
    else $error("hrdata moved");
  a_rdata_unmapped: assert property (rdTake && haddr[7:0] > 8'h17 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  c_irq: cover property (processIrq);
  c_latch_read: cover property (rdTake && haddr[7:0] == 8'h14);
  c_unmapped: cover property (rdTake && haddr[7:0] > 8'h17);
endmodule : guc_counter_asserts

bind guc_counter guc_counter_asserts chk (.mclk(mclk), .reset(reset), .countPulse(countPulse),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .processIrq(processIrq));

// [tb/guc_field_model.sv]
/* field side: count pulses, direction, hw gate, latch pins.
   tasks are entered just after a rising mclk edge. */
module guc_field_model (
  input wire logic mclk,
  output logic countPulse,
  output logic countDown,
  output logic hwGateIn,
  output logic latchIn
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    countPulse = 1'b0;
    countDown = 1'b0;
    hwGateIn = 1'b0;
    latchIn = 1'b0;
  end
  // ========
  // pin tasks, each level held 5 cycles, gate levels 10
  task automatic hold();
    repeat (5) @(posedge mclk);
  endtask : hold
  task automatic pulse(input logic dn);
    countDown <= dn;
    hold();
    countPulse <= 1'b1;
    hold();
    countPulse <= 1'b0;
    hold();
    countDown <= 1'b0;
    hold();
  endtask : pulse
  task automatic gate(input logic v);
    hwGateIn <= v;
    hold();
    hold();
  endtask : gate
  task automatic latch();
    latchIn <= 1'b1;
    hold();
    latchIn <= 1'b0;
    hold();
  endtask : latch
endmodule : guc_field_model

// [tb/gated_updown_counter_modes_tb_top.sv]
/* self-checking bench of guc_counter.
   ahb-lite master tasks, field pin model, read queue and monitor. */
module gated_updown_counter_modes_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rdPend = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] r;
  logic hreadyout, hresp, processIrq, countPulse, countDown, hwGateIn, latchIn;
  logic [31:0] expQ[$];
  int n_mismatch = 0;
  int check_count = 0;
  int irqSeen = 0;
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  guc_field_model fm (.mclk(mclk), .countPulse(countPulse), .countDown(countDown),
    .hwGateIn(hwGateIn), .latchIn(latchIn));
  guc_counter dut (.mclk(mclk), .reset(reset), .countPulse(countPulse), .countDown(countDown),
    .hwGateIn(hwGateIn), .latchIn(latchIn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .processIrq(processIrq));
  // ========
  // compare and close
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : close_out
  // ========
  // bus access, a read notes its expected word
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
    if (!w) begin
      expQ.push_back(d);
    end
    hsel <= 1'b1;
    haddr <= ($urandom() & 32'hffffff00) | {24'h000000, a};
    hsize <= 3'h2;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge mclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= w ? d : 32'h0;
    do @(posedge mclk); while (hreadyout !== 1'b1);
  endtask : acc
  always @(posedge mclk) begin
    if (rdPend) begin
      check("hrdata", hrdata, expQ.pop_front());
    end
    if (processIrq === 1'b1) begin
      irqSeen++;
    end
    rdPend <= hsel && htrans[1] && !hwrite && hreadyout === 1'b1;
  end
  initial begin
    repeat (5000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end
  // ========
  // scenarios
  initial begin
    void'($urandom(32'h7b30));
    r = ($urandom() & 32'h00ffffff) | 32'h00000010;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    acc(0, 8'h08, 32'h0);
    acc(0, 8'h0c, 32'h0);
    acc(0, 8'h10, 32'h64);
    acc(0, 8'h14, 32'h0);
    acc(0, 8'h18, 32'h0);
    acc(1, 8'h0c, r);
    acc(1, 8'h10, r + 32'h3);
    acc(1, 8'h00, 32'h61);
    repeat (2) fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h2);
    fm.pulse(1'b0);
    acc(0, 8'h08, r);
    fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h1);
    acc(1, 8'h00, 32'h0c);
    acc(1, 8'h08, 32'h7fffffff);
    acc(1, 8'h00, 32'h0d);
    fm.pulse(1'b0);
    acc(0, 8'h08, 32'h80000000);
    acc(0, 8'h04, 32'h09);
    fm.pulse(1'b1);
    acc(0, 8'h04, 32'h0b);
    acc(0, 8'h08, 32'h7fffffff);
    acc(1, 8'h04, 32'h1);
    acc(0, 8'h04, 32'h08);
    acc(1, 8'h00, 32'h0c);
    fm.pulse(1'b0);
    acc(0, 8'h08, 32'h7fffffff);
    acc(1, 8'h00, 32'h0d);
    acc(0, 8'h08, 32'h7fffffff);
    acc(1, 8'h00, 32'h08);
    acc(1, 8'h00, 32'h09);
    acc(0, 8'h08, r);
    acc(1, 8'h00, 32'h00);
    acc(1, 8'h00, 32'h51);
    repeat (2) fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h2);
    repeat (2) fm.pulse(1'b0);
    acc(0, 8'h08, r);
    acc(0, 8'h04, 32'h04);
    acc(1, 8'h00, 32'h50);
    acc(1, 8'h00, 32'h51);
    fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h1);
    acc(1, 8'h00, 32'h00);
    acc(1, 8'h10, r - 32'h3);
    acc(1, 8'h00, 32'ha1);
    repeat (2) fm.pulse(1'b1);
    acc(0, 8'h08, r - 32'h2);
    fm.pulse(1'b1);
    acc(0, 8'h08, r);
    acc(1, 8'h00, 32'h90);
    acc(1, 8'h00, 32'h91);
    repeat (4) fm.pulse(1'b1);
    acc(0, 8'h08, r);
    acc(0, 8'h04, 32'h04);
    acc(1, 8'h00, 32'h1c);
    acc(1, 8'h08, 32'h80000000);
    acc(1, 8'h00, 32'h1d);
    repeat (2) fm.pulse(1'b1);
    acc(0, 8'h08, 32'h7fffffff);
    acc(0, 8'h04, 32'h06);
    acc(1, 8'h00, 32'h1c);
    acc(1, 8'h00, 32'h1d);
    fm.pulse(1'b1);
    acc(0, 8'h08, 32'h7ffffffe);
    acc(1, 8'h00, 32'h24);
    acc(1, 8'h00, 32'h25);
    repeat (3) fm.pulse(1'b0);
    acc(0, 8'h08, 32'h80000001);
    acc(0, 8'h04, 32'h0b);
    acc(1, 8'h00, 32'h03);
    fm.pulse(1'b0);
    acc(0, 8'h08, 32'h80000001);
    fm.gate(1'b1);
    fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h1);
    acc(1, 8'h00, 32'h02);
    acc(1, 8'h00, 32'h03);
    fm.pulse(1'b0);
    acc(0, 8'h08, r + 32'h2);
    fm.latch();
    fm.gate(1'b0);
    fm.pulse(1'b0);
    acc(0, 8'h14, r + 32'h2);
    acc(0, 8'h08, r + 32'h2);
    fm.gate(1'b1);
    acc(0, 8'h14, r + 32'h2);
    acc(0, 8'h08, r);
    repeat (4) @(posedge mclk);
    check("irqCount", 32'(irqSeen), 32'h3);
    close_out();
  end
endmodule : gated_updown_counter_modes_tb_top
